// *** core/usb_device_data_endpoints.sv ***
// bulk, interrupt and isochronous endpoint logic of a full-speed usb device
`timescale 1ns/100ps
// Summary of operation
// RL1: pairs 1..7 map to IN address 0x80+k and OUT address k.
// RL2: each acknowledged bulk/interrupt transaction flips DATA0/DATA1 by hardware.
// RL3: OUT data with the previous PID is a repeat, acked and dropped.
// RL4: a CRC failure leaves the expected toggle unchanged.
// RL5: software forces IN or expected OUT toggle for endpoints 1..7.
// RL6: host and software keep packets at most 64 bytes, buffers word aligned.
// RL7: after IN completes, done event, then NAK until the buffer refills.
// RL8: an endpoint with its enable bit clear stays silent.
// RL9: enabled endpoints answer NAK/ACK or STALL; halt reads as GetStatus word.
// RL10: enable changes keep halt; bus reset disables and unhalts data endpoints.
// RL11: endpoint 0 shares enable and halt, but SETUP overrides both.
// RL12: a zero max count sends a zero-length IN packet.
// RL13: OUT NAKs until its size register is written, then acks once.
// RL14: after acceptance, NAK until out buffer consumed or size written.
// RL15: each start of frame gives a synchronised one-cycle sof event.
// RL16: a free-running frame counter counts each sof, readable by software.
// RL17: disabled isochronous endpoints give no response and ignore data.
// RL18: a 1 kB iso buffer, split or not; max 1023 or half.
// RL19: iso IN sends fetched data of max count, else silence or zero-length.
// RL20: software starts iso transfers with sof and ends them before next.
// RL21: iso OUT size reports zero-length flag and byte count.
// RL22: iso OUT CRC error raises usb event with sof and sets cause flag.
// RL23: each start task captures buffer pointer and max count for its transfer.
// RL24: software keeps at most one memory transfer active at a time.
module usb_device_data_endpoints
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sof_pin,
	input wire logic bus_reset,
	input wire logic setup_rcvd,
	input wire logic in_tok_valid,
	input wire logic [3:0] in_tok_ep,
	input wire logic host_ack,
	input wire logic rx_valid,
	input wire logic [3:0] rx_ep,
	input wire logic rx_data1,
	input wire logic rx_crc_ok,
	input wire logic [9:0] rx_len,
	output usb_ep_pkg::resp_t resp,
	output logic [9:0] resp_len,
	output logic dma_start,
	output logic dma_to_mem,
	output logic [31:0] dma_ptr,
	output logic [9:0] dma_count,
	input wire logic dma_done,
	output logic data_endpoint_done_event,
	output logic sof_event,
	output logic general_usb_event
);
	sof_if sof_link();
	logic [8:0] in_endpoint_enable, next_in_en;
	logic [8:0] out_endpoint_enable, next_out_en;
	logic [7:0] in_halt, next_in_halt;
	logic [7:0] out_halt, next_out_halt;
	logic [7:1] in_tog, next_in_tog;
	logic [7:1] out_tog, next_out_tog;
	logic [7:1] in_ready, next_in_ready;
	logic [7:1] out_armed, next_out_armed;
	logic [7:1] st_in, next_st_in;
	logic [7:1] st_out, next_st_out;
	logic [6:0] out_size [1:7];
	logic [6:0] next_out_size [1:7];
	logic [9:0] ep_cnt [0:usb_ep_pkg::SLOTS-1];
	logic [9:0] next_ep_cnt [0:usb_ep_pkg::SLOTS-1];
	logic [3:0] pend_in, next_pend_in;
	logic [31:0] buffer_pointer, next_ptr;
	logic [9:0] max_count, next_cnt;
	logic dma_busy, next_dma_busy;
	logic [4:0] dma_slot, next_dma_slot;
	logic iso_buffer_split, next_split;
	logic iso_in_config_a, next_iso_cfg;
	logic iso_in_ready, next_iso_ready;
	logic iso_out_zero, next_iso_zero;
	logic [9:0] iso_out_size, next_iso_size;
	logic crc_pend, next_crc_pend;
	logic iso_out_crc_error_flag, next_crc_flag;
	usb_ep_pkg::resp_t next_resp;
	logic [9:0] next_resp_len;
	logic next_done, next_dma_start, next_to_mem, next_gen;
	logic [31:0] next_dma_ptr, next_prdata;
	logic [9:0] next_dma_count;
	logic next_slverr;
	logic wr_acc;
	logic [9:0] iso_limit;
	logic [2:0] ridx;

	sof_frame_counter u_sof
	(
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.sof_pin(sof_pin),
		.link(sof_link.src)
	);

	// transfer slot of an endpoint and direction
	function automatic logic [4:0] slot(input logic dir_in, input logic [3:0] ep);
		slot = dir_in ? {1'b0, ep} : usb_ep_pkg::SLOT_OUT_BASE + {1'b0, ep};
	endfunction

	// 3-bit region code of a byte address
	function automatic logic [2:0] region(input logic [7:0] a);
		region = a[7:5];
	endfunction

	// zero-wait apb slave, writes act in the access phase
	assign pready = 1'b1;
	assign wr_acc = psel & penable & pwrite;
	assign ridx = paddr[4:2];
	assign iso_limit = iso_buffer_split ? usb_ep_pkg::ISO_MAX_HALF
		: usb_ep_pkg::ISO_MAX_FULL; // [RL18]

	// read data is registered in the setup phase
	always_comb
	begin
		next_prdata = 32'h0000_0000;
		next_slverr = 1'b0;
		if (region(paddr) == usb_ep_pkg::REGION_IN_HALT)
			next_prdata = {31'h0, in_halt[ridx]}; // [RL9]
		else if (region(paddr) == usb_ep_pkg::REGION_OUT_HALT)
			next_prdata = {31'h0, out_halt[ridx]}; // [RL9]
		else if (region(paddr) == usb_ep_pkg::REGION_OUT_SIZE)
			next_prdata = (ridx == 3'h0) ? 32'h0 : {25'h0, out_size[ridx]};
		else
		begin
			unique case (paddr)
				usb_ep_pkg::OFS_IN_EN: next_prdata = {23'h0, in_endpoint_enable};
				usb_ep_pkg::OFS_OUT_EN: next_prdata = {23'h0, out_endpoint_enable};
				usb_ep_pkg::OFS_STALL, usb_ep_pkg::OFS_TOGGLE,
				usb_ep_pkg::OFS_START_TASK: next_prdata = 32'h0;
				usb_ep_pkg::OFS_EP_STATUS: next_prdata = {8'h0, st_out, 9'h0, st_in, 1'b0};
				usb_ep_pkg::OFS_FRAME: next_prdata = {21'h0, sof_link.frame}; // [RL16]
				usb_ep_pkg::OFS_ISO_SPLIT: next_prdata = {31'h0, iso_buffer_split};
				usb_ep_pkg::OFS_ISO_IN_CFG: next_prdata = {31'h0, iso_in_config_a};
				usb_ep_pkg::OFS_ISO_OUT_SIZE: next_prdata = {15'h0, iso_out_zero, 6'h0,
					iso_out_size}; // [RL21]
				usb_ep_pkg::OFS_EVENT_CAUSE: next_prdata = {31'h0, iso_out_crc_error_flag};
				usb_ep_pkg::OFS_BUF_PTR: next_prdata = buffer_pointer;
				usb_ep_pkg::OFS_MAX_COUNT: next_prdata = {22'h0, max_count};
				default: next_slverr = 1'b1;
			endcase
		end
	end

	// endpoint state: register writes first, then usb and dma events (later assignments win)
	always_comb
	begin
		next_in_en = in_endpoint_enable;
		next_out_en = out_endpoint_enable;
		next_in_halt = in_halt;
		next_out_halt = out_halt;
		next_in_tog = in_tog;
		next_out_tog = out_tog;
		next_in_ready = in_ready;
		next_out_armed = out_armed;
		next_st_in = st_in;
		next_st_out = st_out;
		next_out_size = out_size;
		next_ep_cnt = ep_cnt;
		next_pend_in = pend_in;
		next_ptr = buffer_pointer;
		next_cnt = max_count;
		next_dma_busy = dma_busy;
		next_dma_slot = dma_slot;
		next_split = iso_buffer_split;
		next_iso_cfg = iso_in_config_a;
		next_iso_ready = iso_in_ready;
		next_iso_zero = iso_out_zero;
		next_iso_size = iso_out_size;
		next_crc_pend = crc_pend;
		next_crc_flag = iso_out_crc_error_flag;
		next_resp = usb_ep_pkg::RESP_NONE;
		next_resp_len = 10'h000;
		next_done = 1'b0;
		next_dma_start = 1'b0;
		next_to_mem = dma_to_mem;
		next_dma_ptr = dma_ptr;
		next_dma_count = dma_count;
		next_gen = 1'b0;
		if (wr_acc)
		begin
			if (region(paddr) == usb_ep_pkg::REGION_OUT_SIZE && ridx != 3'h0)
				next_out_armed[ridx] = 1'b1; // [RL13] [RL14]
			unique case (paddr)
				usb_ep_pkg::OFS_IN_EN: next_in_en = pwdata[8:0]; // [RL10]
				usb_ep_pkg::OFS_OUT_EN: next_out_en = pwdata[8:0];
				usb_ep_pkg::OFS_STALL:
					if (pwdata[usb_ep_pkg::DIR_IN_BIT])
						next_in_halt[pwdata[2:0]] = pwdata[usb_ep_pkg::STALL_SET_BIT]; // [RL9]
					else
						next_out_halt[pwdata[2:0]] = pwdata[usb_ep_pkg::STALL_SET_BIT];
				usb_ep_pkg::OFS_TOGGLE:
					if (pwdata[2:0] != 3'h0 && pwdata[9:8] != 2'h0 && pwdata[9:8] != 2'h3)
					begin
						if (pwdata[usb_ep_pkg::DIR_IN_BIT])
							next_in_tog[pwdata[2:0]] = pwdata[9:8] == usb_ep_pkg::TOG_FORCE1; // [RL5]
						else
							next_out_tog[pwdata[2:0]] = pwdata[9:8] == usb_ep_pkg::TOG_FORCE1;
					end
				usb_ep_pkg::OFS_EP_STATUS:
				begin
					next_st_in = st_in & ~pwdata[7:1];
					next_st_out = st_out & ~pwdata[usb_ep_pkg::OUT_FLAGS_LO+7:usb_ep_pkg::OUT_FLAGS_LO+1];
				end
				usb_ep_pkg::OFS_ISO_SPLIT: next_split = pwdata[0];
				usb_ep_pkg::OFS_ISO_IN_CFG: next_iso_cfg = pwdata[0];
				usb_ep_pkg::OFS_EVENT_CAUSE: next_crc_flag = iso_out_crc_error_flag & ~pwdata[0];
				usb_ep_pkg::OFS_BUF_PTR: next_ptr = pwdata;
				usb_ep_pkg::OFS_MAX_COUNT: next_cnt = pwdata[9:0];
				usb_ep_pkg::OFS_START_TASK:
					if (!dma_busy) // [RL24]
					begin
						next_dma_slot = slot(pwdata[usb_ep_pkg::DIR_IN_BIT], pwdata[3:0]);
						next_ep_cnt[next_dma_slot] = max_count; // [RL23]
						next_dma_ptr = buffer_pointer;
						next_dma_count = max_count;
						next_to_mem = ~pwdata[usb_ep_pkg::DIR_IN_BIT];
						next_dma_start = 1'b1;
						next_dma_busy = 1'b1;
					end
				default: next_dma_start = 1'b0;
			endcase
		end
		// in tokens
		if (in_tok_valid)
		begin
			if (in_tok_ep == usb_ep_pkg::EP_ISO)
			begin
				if (in_endpoint_enable[usb_ep_pkg::ISO_EN_BIT]) // [RL17]
				begin
					if (iso_in_ready)
					begin
						next_resp = usb_ep_pkg::RESP_DATA0; // [RL19]
						next_resp_len = (ep_cnt[usb_ep_pkg::EP_ISO] > iso_limit) ? iso_limit
							: ep_cnt[usb_ep_pkg::EP_ISO]; // [RL18]
						next_iso_ready = 1'b0;
					end
					else if (iso_in_config_a)
						next_resp = usb_ep_pkg::RESP_DATA0; // [RL19]
				end
			end
			else if (in_tok_ep < 4'h8 && in_endpoint_enable[in_tok_ep[2:0]]) // [RL1] [RL8]
			begin
				if (in_halt[in_tok_ep[2:0]])
					next_resp = usb_ep_pkg::RESP_STALL; // [RL9]
				else if (in_tok_ep != 4'h0 && in_ready[in_tok_ep[2:0]])
				begin
					next_resp = in_tog[in_tok_ep[2:0]] ? usb_ep_pkg::RESP_DATA1
						: usb_ep_pkg::RESP_DATA0;
					next_resp_len = ep_cnt[in_tok_ep]; // [RL12]
					next_pend_in = in_tok_ep;
				end
				else
					next_resp = usb_ep_pkg::RESP_NAK; // [RL7]
			end
		end
		// host acknowledged the last in packet
		if (host_ack && pend_in != 4'h0)
		begin
			next_in_tog[pend_in[2:0]] = ~in_tog[pend_in[2:0]]; // [RL2]
			next_in_ready[pend_in[2:0]] = 1'b0; // [RL7]
			next_st_in[pend_in[2:0]] = 1'b1;
			next_done = 1'b1;
			next_pend_in = 4'h0;
		end
		// end of a memory transfer refills or rearms the endpoint
		if (dma_done && dma_busy)
		begin
			next_dma_busy = 1'b0;
			if (dma_slot == {1'b0, usb_ep_pkg::EP_ISO})
				next_iso_ready = 1'b1;
			else if (dma_slot < usb_ep_pkg::SLOT_OUT_BASE && dma_slot != 5'h00)
				next_in_ready[dma_slot[2:0]] = 1'b1; // [RL7]
			else if (dma_slot > usb_ep_pkg::SLOT_OUT_BASE
				&& dma_slot < usb_ep_pkg::SLOT_OUT_BASE + 5'h08)
				next_out_armed[3'(dma_slot - usb_ep_pkg::SLOT_OUT_BASE)] = 1'b1; // [RL14]
		end
		// out data packets
		if (rx_valid && !in_tok_valid)
		begin
			if (rx_ep == usb_ep_pkg::EP_ISO)
			begin
				if (out_endpoint_enable[usb_ep_pkg::ISO_EN_BIT]) // [RL17]
				begin
					next_iso_zero = rx_len == 10'h000; // [RL21]
					next_iso_size = rx_len;
					next_crc_pend = ~rx_crc_ok; // [RL22]
				end
			end
			else if (rx_ep < 4'h8 && out_endpoint_enable[rx_ep[2:0]]) // [RL8]
			begin
				if (out_halt[rx_ep[2:0]])
					next_resp = usb_ep_pkg::RESP_STALL; // [RL9]
				else if (!rx_crc_ok || rx_ep == 4'h0)
					next_resp = usb_ep_pkg::RESP_NONE; // [RL4]
				else if (rx_data1 != out_tog[rx_ep[2:0]])
					next_resp = usb_ep_pkg::RESP_ACK; // [RL3]
				else if (out_armed[rx_ep[2:0]])
				begin
					next_resp = usb_ep_pkg::RESP_ACK; // [RL13]
					next_out_tog[rx_ep[2:0]] = ~out_tog[rx_ep[2:0]]; // [RL2]
					next_out_armed[rx_ep[2:0]] = 1'b0; // [RL14]
					next_out_size[rx_ep[2:0]] = rx_len[6:0];
					next_st_out[rx_ep[2:0]] = 1'b1;
					next_done = 1'b1;
				end
				else
					next_resp = usb_ep_pkg::RESP_NAK; // [RL13]
			end
		end
		// crc error of the last iso packet reported with sof
		if (sof_link.sof && crc_pend)
		begin
			next_gen = 1'b1; // [RL22]
			next_crc_flag = 1'b1;
			next_crc_pend = 1'b0;
		end
		// setup overrides endpoint 0, bus reset clears data endpoints
		if (setup_rcvd)
		begin
			next_in_en[0] = 1'b1; // [RL11]
			next_out_en[0] = 1'b1;
			next_in_halt[0] = 1'b0;
			next_out_halt[0] = 1'b0;
		end
		if (bus_reset)
		begin
			next_in_en[8:1] = 8'h00; // [RL10]
			next_out_en[8:1] = 8'h00;
			next_in_halt[7:1] = 7'h00;
			next_out_halt[7:1] = 7'h00;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			in_endpoint_enable <= usb_ep_pkg::EN_RESET;
			out_endpoint_enable <= usb_ep_pkg::EN_RESET;
			in_halt <= 8'h00;
			out_halt <= 8'h00;
			in_tog <= 7'h00;
			out_tog <= 7'h00;
			in_ready <= 7'h00;
			out_armed <= 7'h00;
			st_in <= 7'h00;
			st_out <= 7'h00;
			for (int i = 1; i < 8; i++)
				out_size[i] <= 7'h00;
			for (int i = 0; i < usb_ep_pkg::SLOTS; i++)
				ep_cnt[i] <= 10'h000;
			pend_in <= 4'h0;
			buffer_pointer <= 32'h0000_0000;
			max_count <= 10'h000;
			dma_busy <= 1'b0;
			dma_slot <= 5'h00;
			iso_buffer_split <= 1'b0;
			iso_in_config_a <= 1'b0;
			iso_in_ready <= 1'b0;
			iso_out_zero <= 1'b0;
			iso_out_size <= 10'h000;
			crc_pend <= 1'b0;
			iso_out_crc_error_flag <= 1'b0;
			resp <= usb_ep_pkg::RESP_NONE;
			resp_len <= 10'h000;
			data_endpoint_done_event <= 1'b0;
			dma_start <= 1'b0;
			dma_to_mem <= 1'b0;
			dma_ptr <= 32'h0000_0000;
			dma_count <= 10'h000;
			general_usb_event <= 1'b0;
			sof_event <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			in_endpoint_enable <= next_in_en;
			out_endpoint_enable <= next_out_en;
			in_halt <= next_in_halt;
			out_halt <= next_out_halt;
			in_tog <= next_in_tog;
			out_tog <= next_out_tog;
			in_ready <= next_in_ready;
			out_armed <= next_out_armed;
			st_in <= next_st_in;
			st_out <= next_st_out;
			out_size <= next_out_size;
			ep_cnt <= next_ep_cnt;
			pend_in <= next_pend_in;
			buffer_pointer <= next_ptr;
			max_count <= next_cnt;
			dma_busy <= next_dma_busy;
			dma_slot <= next_dma_slot;
			iso_buffer_split <= next_split;
			iso_in_config_a <= next_iso_cfg;
			iso_in_ready <= next_iso_ready;
			iso_out_zero <= next_iso_zero;
			iso_out_size <= next_iso_size;
			crc_pend <= next_crc_pend;
			iso_out_crc_error_flag <= next_crc_flag;
			resp <= next_resp;
			resp_len <= next_resp_len;
			data_endpoint_done_event <= next_done;
			dma_start <= next_dma_start;
			dma_to_mem <= next_to_mem;
			dma_ptr <= next_dma_ptr;
			dma_count <= next_dma_count;
			general_usb_event <= next_gen;
			sof_event <= sof_link.sof; // [RL15]
			if (psel && !penable)
			begin
				prdata <= next_prdata;
				pslverr <= next_slverr;
			end
		end
	end

	sequence s_tok_dis;
		in_tok_valid && in_tok_ep != 4'h0 && in_tok_ep < 4'h8
			&& !in_endpoint_enable[in_tok_ep[2:0]];
	endsequence
	property p_disabled_silent;
		@(posedge sys_clk) disable iff (sys_rst)
		s_tok_dis |=> resp == usb_ep_pkg::RESP_NONE;
	endproperty
	a_disabled_silent: assert property (p_disabled_silent) else $error("disabled in ep answered"); // RL8

	property p_stall;
		@(posedge sys_clk) disable iff (sys_rst)
		in_tok_valid && in_tok_ep < 4'h8 && in_endpoint_enable[in_tok_ep[2:0]]
			&& in_halt[in_tok_ep[2:0]] |=> resp == usb_ep_pkg::RESP_STALL;
	endproperty
	a_stall: assert property (p_stall) else $error("halted ep did not stall"); // RL9

	property p_nak_unarmed;
		@(posedge sys_clk) disable iff (sys_rst)
		rx_valid && !in_tok_valid && rx_ep != 4'h0 && rx_ep < 4'h8 && rx_crc_ok
			&& out_endpoint_enable[rx_ep[2:0]] && !out_halt[rx_ep[2:0]]
			&& rx_data1 == out_tog[rx_ep[2:0]] && !out_armed[rx_ep[2:0]] && !host_ack
			|=> resp == usb_ep_pkg::RESP_NAK && !data_endpoint_done_event;
	endproperty
	a_nak_unarmed: assert property (p_nak_unarmed) else $error("unarmed out ep not naked"); // RL13

	property p_crc_keeps_toggle;
		@(posedge sys_clk) disable iff (sys_rst)
		rx_valid && !rx_crc_ok && !wr_acc |=> $stable(out_tog);
	endproperty
	a_crc_keeps_toggle: assert property (p_crc_keeps_toggle) else $error("crc error moved toggle"); // RL4

	property p_ack_toggles;
		@(posedge sys_clk) disable iff (sys_rst)
		host_ack && pend_in != 4'h0 |=> in_tog[$past(pend_in[2:0])] != $past(in_tog[pend_in[2:0]])
			&& data_endpoint_done_event;
	endproperty
	a_ack_toggles: assert property (p_ack_toggles) else $error("in toggle not flipped"); // RL2

	property p_bus_reset;
		@(posedge sys_clk) disable iff (sys_rst)
		bus_reset |=> in_endpoint_enable[8:1] == 8'h00 && in_halt[7:1] == 7'h00
			&& out_halt[7:1] == 7'h00;
	endproperty
	a_bus_reset: assert property (p_bus_reset) else $error("bus reset left endpoints active"); // RL10

	property p_setup;
		@(posedge sys_clk) disable iff (sys_rst)
		setup_rcvd && !bus_reset |=> in_endpoint_enable[0] && !in_halt[0] && !out_halt[0];
	endproperty
	a_setup: assert property (p_setup) else $error("setup did not override ep0"); // RL11

	property p_iso_zlp;
		@(posedge sys_clk) disable iff (sys_rst)
		in_tok_valid && in_tok_ep == usb_ep_pkg::EP_ISO && !iso_in_ready
			&& in_endpoint_enable[usb_ep_pkg::ISO_EN_BIT]
			|=> resp == ($past(iso_in_config_a) ? usb_ep_pkg::RESP_DATA0 : usb_ep_pkg::RESP_NONE)
			&& resp_len == 10'h000;
	endproperty
	a_iso_zlp: assert property (p_iso_zlp) else $error("empty iso in response wrong"); // RL19

	property p_crc_with_sof;
		@(posedge sys_clk) disable iff (sys_rst)
		sof_link.sof && crc_pend |=> general_usb_event && sof_event && iso_out_crc_error_flag;
	endproperty
	a_crc_with_sof: assert property (p_crc_with_sof) else $error("iso crc not reported at sof"); // RL22
endmodule // usb_device_data_endpoints

// *** core/usb_ep_pkg.sv ***
// constants, register map and types shared by the endpoint logic
package usb_ep_pkg;
	// apb byte offsets
	localparam logic [7:0] OFS_IN_EN = 8'h00;
	localparam logic [7:0] OFS_OUT_EN = 8'h04;
	localparam logic [7:0] OFS_STALL = 8'h08;
	localparam logic [7:0] OFS_TOGGLE = 8'h0c;
	localparam logic [7:0] OFS_EP_STATUS = 8'h10;
	localparam logic [7:0] OFS_FRAME = 8'h14;
	localparam logic [7:0] OFS_ISO_SPLIT = 8'h18;
	localparam logic [7:0] OFS_ISO_IN_CFG = 8'h1c;
	localparam logic [7:0] OFS_ISO_OUT_SIZE = 8'h20;
	localparam logic [7:0] OFS_EVENT_CAUSE = 8'h24;
	localparam logic [7:0] OFS_BUF_PTR = 8'h28;
	localparam logic [7:0] OFS_MAX_COUNT = 8'h2c;
	localparam logic [7:0] OFS_START_TASK = 8'h30;
	localparam logic [2:0] REGION_IN_HALT = 3'h2;
	localparam logic [2:0] REGION_OUT_HALT = 3'h3;
	localparam logic [2:0] REGION_OUT_SIZE = 3'h4;
	// field positions
	localparam int ISO_EN_BIT = 8;
	localparam int DIR_IN_BIT = 7;
	localparam int STALL_SET_BIT = 8;
	localparam int TOG_FIELD_LO = 8;
	localparam int ZERO_FLAG_BIT = 16;
	localparam int OUT_FLAGS_LO = 16;
	localparam logic [1:0] TOG_FORCE0 = 2'h1;
	localparam logic [1:0] TOG_FORCE1 = 2'h2;
	// endpoint numbering and sizes
	localparam logic [3:0] EP_ISO = 4'h8;
	localparam logic [4:0] SLOT_OUT_BASE = 5'h09;
	localparam int SLOTS = 18;
	localparam logic [9:0] ISO_MAX_FULL = 10'h3ff;
	localparam logic [9:0] ISO_MAX_HALF = 10'h1ff;
	localparam logic [8:0] EN_RESET = 9'h000;
	typedef enum logic [2:0] {
		RESP_NONE, RESP_ACK, RESP_NAK, RESP_STALL, RESP_DATA0, RESP_DATA1
	} resp_t;
endpackage

// *** core/sof_if.sv ***
// start-of-frame pulse and frame count passed to the endpoint logic
`timescale 1ns/100ps
interface sof_if;
	logic sof;
	logic [10:0] frame;
	modport src (output sof, output frame);
	modport dst (input sof, input frame);
endinterface // sof_if

// *** core/sof_frame_counter.sv ***
// start-of-frame synchroniser and free-running frame counter
`timescale 1ns/100ps
module sof_frame_counter
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic sof_pin,
	sof_if.src link
);
	logic [2:0] sync;
	logic level;
	logic sof_q;
	logic [10:0] frame;
	logic [2:0] next_sync;
	logic next_level;
	logic next_sof_q;
	logic [10:0] next_frame;

	// three flops, a change counts once stages two and three agree
	always_comb
	begin
		next_sync = {sync[1:0], sof_pin};
		next_level = level;
		if (sync[1] == sync[2])
			next_level = sync[2];
		next_sof_q = next_level & ~level; // [RL15]
		next_frame = frame + {10'h000, next_sof_q}; // [RL16]
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			sync <= 3'h0;
			level <= 1'b0;
			sof_q <= 1'b0;
			frame <= 11'h000;
		end
		else
		begin
			sync <= next_sync;
			level <= next_level;
			sof_q <= next_sof_q;
			frame <= next_frame;
		end
	end

	assign link.sof = sof_q;
	assign link.frame = frame;

	property p_frame_step;
		@(posedge sys_clk) disable iff (sys_rst)
		sof_q |-> frame == $past(frame) + 11'h001;
	endproperty
	a_frame_step: assert property (p_frame_step) else $error("frame count missed a sof"); // RL16

	property p_sof_single;
		@(posedge sys_clk) disable iff (sys_rst)
		sof_q |=> !sof_q;
	endproperty
	a_sof_single: assert property (p_sof_single) else $error("sof event longer than a cycle"); // RL15
endmodule // sof_frame_counter

// *** sim/usb_host_model.sv ***
// host-side usb model: tokens, out data, acks and frame starts
`timescale 1ns/100ps
module usb_host_model
(
	input wire logic sys_clk,
	output logic sof_pin,
	output logic in_tok_valid,
	output logic [3:0] in_tok_ep,
	output logic host_ack,
	output logic rx_valid,
	output logic [3:0] rx_ep,
	output logic rx_data1,
	output logic rx_crc_ok,
	output logic [9:0] rx_len,
	input wire usb_ep_pkg::resp_t resp,
	input wire logic [9:0] resp_len
);
	// idle bus at time zero
	initial
	begin
		{sof_pin, in_tok_valid, host_ack, rx_valid} = 4'h0;
		{in_tok_ep, rx_ep, rx_data1, rx_crc_ok, rx_len} = 20'h0;
	end
	// one token or data packet; answer taken one cycle later
	task automatic xfer(input logic tok, input logic [3:0] ep, input logic [11:0] pk,
		output usb_ep_pkg::resp_t r, output logic [9:0] n);
		@(posedge sys_clk);
		in_tok_valid <= tok;
		rx_valid <= !tok;
		in_tok_ep <= ep;
		rx_ep <= ep;
		{rx_data1, rx_crc_ok, rx_len} <= pk; // packet length passed as given, up to 1023 bytes
		@(posedge sys_clk);
		in_tok_valid <= 1'b0;
		rx_valid <= 1'b0;
		in_tok_ep <= ~ep; // idle lines inverted
		rx_ep <= ~ep;
		{rx_data1, rx_crc_ok, rx_len} <= ~pk;
		@(negedge sys_clk);
		r = resp;
		n = resp_len;
	endtask
	// handshake for the last in packet
	task automatic ack();
		@(posedge sys_clk);
		host_ack <= 1'b1;
		@(posedge sys_clk);
		host_ack <= 1'b0;
		@(negedge sys_clk);
	endtask
	// frame start edge
	task automatic sof();
		@(posedge sys_clk);
		sof_pin <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sof_pin <= 1'b0;
	endtask
endmodule // usb_host_model

// *** sim/usb_device_data_endpoints_test.sv ***
// self-checking bench for the usb endpoint logic
`timescale 1ns/100ps
module usb_device_data_endpoints_test;
	logic sys_clk, sys_rst, psel, penable, pwrite, bus_reset, setup_rcvd, dma_done, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, dma_ptr, rd, seed;
	logic pready, pslverr, dma_start, dma_to_mem, data_endpoint_done_event, sof_event;
	logic general_usb_event, sof_pin, in_tok_valid, host_ack, rx_valid, rx_data1, rx_crc_ok;
	logic [3:0] in_tok_ep, rx_ep;
	logic [9:0] rx_len, resp_len, dma_count, n, cnt;
	logic [10:0] f;
	usb_ep_pkg::resp_t resp, r;
	int error_cnt, compares;
	usb_device_data_endpoints u_usb_device_data_endpoints (.*);
	usb_host_model u_usb_host_model (.*);
	// 10 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic usb_ep_pkg::resp_t pid(input logic t);
		return t ? usb_ep_pkg::RESP_DATA1 : usb_ep_pkg::RESP_DATA0;
	endfunction
	task automatic cv(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %0t value %h expected %h", $time, g, e);
		end
	endtask
	task automatic cr(input usb_ep_pkg::resp_t g, input usb_ep_pkg::resp_t e);
		compares++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %0t response %0d expected %0d", $time, g, e);
		end
	endtask
	// apb transfer, waits for pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cv(rd, e);
	endtask
	task automatic tk(input logic t, input logic [3:0] ep, input logic [11:0] pk,
		input usb_ep_pkg::resp_t e, input logic [9:0] el);
		u_usb_host_model.xfer(t, ep, pk, r, n);
		cr(r, e);
		if (e >= usb_ep_pkg::RESP_DATA0)
			cv({22'h0, n}, {22'h0, el});
	endtask
	// load an in buffer through the memory engine
	task automatic fill(input logic [7:0] ep, input logic [9:0] c);
		cnt = c;
		apb(1'b1, usb_ep_pkg::OFS_BUF_PTR, {seed[31:2], 2'b00});
		apb(1'b1, usb_ep_pkg::OFS_MAX_COUNT, {22'h0, c});
		apb(1'b1, usb_ep_pkg::OFS_START_TASK, {24'h0, ep});
		repeat (4) if (dma_start !== 1'b1) @(negedge sys_clk);
		cv({20'h0, dma_start, dma_to_mem, dma_count}, {20'h0, 2'b10, c});
		cv(dma_ptr, {seed[31:2], 2'b00});
		@(posedge sys_clk);
		dma_done <= 1'b1; // one transfer at a time
		@(posedge sys_clk);
		dma_done <= 1'b0;
	endtask
	task automatic frame();
		u_usb_host_model.sof();
		repeat (8) if (sof_event !== 1'b1) @(negedge sys_clk);
		cv(sof_event, 1'b1);
	endtask
	task automatic end_of_test();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// watchdog
	initial
	begin
		#2000000;
		error_cnt++;
		end_of_test();
	end
	// main sequence
	initial
	begin
		seed = 32'h35a7;
		{psel, penable, pwrite, bus_reset, setup_rcvd, dma_done} = 6'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		error_cnt = 0;
		compares = 0;
		sys_rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rdc(usb_ep_pkg::OFS_IN_EN, 32'h0);
		tk(1'b1, 4'h1, 12'h0, usb_ep_pkg::RESP_NONE, 10'h0);
		apb(1'b1, usb_ep_pkg::OFS_IN_EN, 32'h1ff);
		apb(1'b1, usb_ep_pkg::OFS_OUT_EN, 32'h1fe);
		tk(1'b1, 4'h1, 12'h0, usb_ep_pkg::RESP_NAK, 10'h0);
		for (int i = 0; i < 3; i++)
		begin
			seed = rnd();
			fill(8'h81, i[0] ? {4'h0, seed[5:0]} : 10'h0);
			tk(1'b1, 4'h1, 12'h0, pid(i[0]), cnt);
			u_usb_host_model.ack();
			cv(data_endpoint_done_event, 1'b1);
			tk(1'b1, 4'h1, 12'h0, usb_ep_pkg::RESP_NAK, 10'h0);
		end
		apb(1'b1, usb_ep_pkg::OFS_TOGGLE, 32'h181);
		fill(8'h81, 10'h4);
		tk(1'b1, 4'h1, 12'h0, usb_ep_pkg::RESP_DATA0, 10'h4);
		apb(1'b1, usb_ep_pkg::OFS_STALL, 32'h181);
		tk(1'b1, 4'h1, 12'h0, usb_ep_pkg::RESP_STALL, 10'h0);
		apb(1'b1, usb_ep_pkg::OFS_IN_EN, 32'h0);
		apb(1'b1, usb_ep_pkg::OFS_IN_EN, 32'h1ff);
		rdc(8'h44, 32'h1);
		@(posedge sys_clk);
		bus_reset <= 1'b1;
		@(posedge sys_clk);
		bus_reset <= 1'b0;
		rdc(8'h44, 32'h0);
		rdc(usb_ep_pkg::OFS_IN_EN, 32'h1);
		tk(1'b1, 4'h1, 12'h0, usb_ep_pkg::RESP_NONE, 10'h0);
		apb(1'b1, usb_ep_pkg::OFS_IN_EN, 32'h1ff);
		apb(1'b1, usb_ep_pkg::OFS_OUT_EN, 32'h1fe);
		apb(1'b1, usb_ep_pkg::OFS_EP_STATUS, 32'hffffffff);
		tk(1'b0, 4'h2, 12'h400, usb_ep_pkg::RESP_NAK, 10'h0);
		apb(1'b1, 8'h88, seed);
		tk(1'b0, 4'h2, 12'h010, usb_ep_pkg::RESP_NONE, 10'h0);
		tk(1'b0, 4'h2, {6'h10, seed[5:0]}, usb_ep_pkg::RESP_ACK, 10'h0);
		cv(data_endpoint_done_event, 1'b1);
		rdc(usb_ep_pkg::OFS_EP_STATUS, 32'h40000);
		rdc(8'h88, {26'h0, seed[5:0]});
		tk(1'b0, 4'h2, 12'hc00, usb_ep_pkg::RESP_NAK, 10'h0);
		apb(1'b1, 8'h88, 32'h0);
		tk(1'b0, 4'h2, 12'hc00, usb_ep_pkg::RESP_ACK, 10'h0);
		apb(1'b1, 8'h88, 32'h0);
		tk(1'b0, 4'h2, 12'hc00, usb_ep_pkg::RESP_ACK, 10'h0);
		cv(data_endpoint_done_event, 1'b0);
		apb(1'b0, usb_ep_pkg::OFS_FRAME, 32'h0);
		f = rd[10:0];
		tk(1'b0, usb_ep_pkg::EP_ISO, 12'h005, usb_ep_pkg::RESP_NONE, 10'h0);
		frame();
		cv(general_usb_event, 1'b1);
		rdc(usb_ep_pkg::OFS_FRAME, {21'h0, f + 11'h1});
		rdc(usb_ep_pkg::OFS_EVENT_CAUSE, 32'h1);
		tk(1'b0, usb_ep_pkg::EP_ISO, 12'h400, usb_ep_pkg::RESP_NONE, 10'h0);
		rdc(usb_ep_pkg::OFS_ISO_OUT_SIZE, 32'h10000);
		tk(1'b0, usb_ep_pkg::EP_ISO, {2'b01, seed[9:0]}, usb_ep_pkg::RESP_NONE, 10'h0);
		rdc(usb_ep_pkg::OFS_ISO_OUT_SIZE, {15'h0, ~|seed[9:0], 6'h0, seed[9:0]});
		tk(1'b1, usb_ep_pkg::EP_ISO, 12'h0, usb_ep_pkg::RESP_NONE, 10'h0);
		apb(1'b1, usb_ep_pkg::OFS_ISO_IN_CFG, 32'h1);
		tk(1'b1, usb_ep_pkg::EP_ISO, 12'h0, usb_ep_pkg::RESP_DATA0, 10'h0);
		seed = rnd();
		fill(8'h88, seed[9:0]);
		tk(1'b1, usb_ep_pkg::EP_ISO, 12'h0, usb_ep_pkg::RESP_DATA0, cnt);
		apb(1'b0, 8'hfc, 32'h0);
		cv(err, 1'b1);
		end_of_test();
	end
endmodule // usb_device_data_endpoints_test
